// ===== core/flash_access_guard.sv
/*
 * Flash access guard: judges each CPU flash read, write and erase
 * against the lock state of the target and of the executing code,
 * the store enables, the key sequence and the supply monitor.
 * Assumes one request per cycle at most, synchronous to sys_clk,
 * and lock bytes already fetched from flash by the array side.
 */
// Decided for this implementation: the address-and-strobe port and the register addresses.
// What this block does
// - Main area split into 512-byte pages
// - Data area: 1 KB in 64-byte pages
// - Writes need store write enable set
// - Erases need both store enables set
// - Complement of user-lock byte locks pages
// - Data-lock byte all ones opens data
// - Other data-lock values lock whole data area
// - User security page locked unless byte ones
// - Open user pages accessible from anywhere
// - Locked user pages: locked code only
// - Locked user security page: no erase
// - Open data pages accessible from anywhere
// - Locked data pages: locked code only
// - Locked data security page: no erase
// - Open code on locked pages, or reserved space: flash error reset
// - Two key codes in order unlock
// - Key consumed per operation; early try disables
// - Supply monitor off: write/erase resets
`default_nettype none
module flash_access_guard
	import flash_guard_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [REG_AW-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [DATA_W-1:0] regRdata,
	input wire logic reqValid,
	input wire flash_req_t req,
	input wire logic [ADDR_W-1:0] execAddr,
	input wire logic [7:0] userLockByte,
	input wire logic [7:0] dataLockByte,
	input wire logic supplyMonOn,
	input wire logic supplyMonIsReset,
	output logic grantValid,
	output flash_req_t grant,
	output logic refused,
	output logic flashErrorReset
);
	////////////////////////////////////////////////////////////////
	flash_area_t targetArea;
	flash_area_t execArea;
	key_state_t keyState_reg, keyState_next;
	logic [1:0] control_reg, control_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	flash_req_t grant_reg, grant_next;
	logic grantValid_reg, grantValid_next;
	logic refused_reg, refused_next;
	logic errReset_reg, errReset_next;
	logic execLocked;
	logic areaOk;
	logic areaReset;
	logic isModify;

	function automatic logic lockedArea(input flash_area_t a);
		lockedArea = a == AREA_USER_LOCKED || a == AREA_USER_SEC ||
			a == AREA_DATA_LOCKED || a == AREA_DATA_SEC;
	endfunction : lockedArea

	flash_region_decode targetDecode (
		.addr(req.addr),
		.userLockByte(userLockByte),
		.dataLockByte(dataLockByte),
		.area(targetArea)
	);

	flash_region_decode execDecode (
		.addr(execAddr),
		.userLockByte(userLockByte),
		.dataLockByte(dataLockByte),
		.area(execArea)
	);

	////////////////////////////////////////////////////////////////
	// Permission table: code in read-only or reserved space counts
	// as open code, the safe reading.
	always_comb begin
		execLocked = lockedArea(execArea);
		isModify = req.op != OP_READ;
		areaOk = 1'b0;
		areaReset = 1'b0;
		case (targetArea)
			AREA_USER_OPEN, AREA_DATA_OPEN: begin
				areaOk = 1'b1;
			end
			AREA_USER_LOCKED, AREA_DATA_LOCKED: begin
				areaOk = execLocked;
				areaReset = !execLocked;
			end
			AREA_USER_SEC, AREA_DATA_SEC: begin
				// Erasing the security page would silently unlock
				areaOk = execLocked && req.op != OP_ERASE;
				areaReset = !execLocked;
			end
			AREA_READ_ONLY: begin
				areaOk = req.op == OP_READ;
			end
			default: begin
				areaReset = 1'b1;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	always_comb begin
		keyState_next = keyState_reg;
		control_next = control_reg;
		rdata_next = '0;
		grant_next = grant_reg;
		grantValid_next = 1'b0;
		refused_next = 1'b0;
		errReset_next = 1'b0;

		// Register port
		if (regWrite) begin
			if (regAddr == REG_CONTROL) begin
				control_next = regWdata[1:0];
			end else if (regAddr == REG_KEY) begin
				case (keyState_reg)
					KEY_IDLE: begin
						keyState_next = (regWdata == KEY_CODE_FIRST) ?
							KEY_HALF : KEY_DEAD;
					end
					KEY_HALF: begin
						keyState_next = (regWdata == KEY_CODE_SECOND) ?
							KEY_ARMED : KEY_DEAD;
					end
					default: begin
						keyState_next = KEY_DEAD;
					end
				endcase
			end
		end
		if (regRead) begin
			if (regAddr == REG_CONTROL) begin
				rdata_next = {{(DATA_W-2){1'b0}}, control_reg};
			end else if (regAddr == REG_KEY) begin
				rdata_next = {{(DATA_W-2){1'b0}}, keyState_reg};
			end else if (regAddr == REG_STATUS) begin
				rdata_next = {{(DATA_W-2){1'b0}},
					dataLockByte != LOCK_OPEN,
					userLockByte != LOCK_OPEN};
			end else begin
				rdata_next = '0;
			end
		end

		// Flash requests
		if (reqValid) begin
			if (areaReset) begin
				errReset_next = 1'b1;
			end else if (!areaOk) begin
				refused_next = 1'b1;
			end else if (!isModify) begin
				grantValid_next = 1'b1;
				grant_next = req;
			end else if (!control_reg[CTRL_WE_BIT] ||
				(req.op == OP_ERASE &&
				!control_reg[CTRL_EE_BIT])) begin
				refused_next = 1'b1;
			end else if (!supplyMonOn || !supplyMonIsReset) begin
				errReset_next = 1'b1;
			end else if (keyState_reg != KEY_ARMED) begin
				refused_next = 1'b1;
				keyState_next = KEY_DEAD;
			end else begin
				grantValid_next = 1'b1;
				grant_next = req;
				keyState_next = KEY_IDLE;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			keyState_reg <= KEY_IDLE;
			control_reg <= CTRL_RESET;
			rdata_reg <= '0;
			grant_reg <= '0;
			grantValid_reg <= 1'b0;
			refused_reg <= 1'b0;
			errReset_reg <= 1'b0;
		end else begin
			keyState_reg <= keyState_next;
			control_reg <= control_next;
			rdata_reg <= rdata_next;
			grant_reg <= grant_next;
			grantValid_reg <= grantValid_next;
			refused_reg <= refused_next;
			errReset_reg <= errReset_next;
		end
	end

	assign regRdata = rdata_reg;
	assign grantValid = grantValid_reg;
	assign grant = grant_reg;
	assign refused = refused_reg;
	assign flashErrorReset = errReset_reg;
endmodule : flash_access_guard
`default_nettype wire

// ===== core/flash_guard_pkg.sv
/*
 * Shared constants and types of the flash access guard: flash map,
 * page sizes, key codes, register offsets, request and area types.
 * Assumes a 16-bit flash byte address and byte-wide register port.
 */
`default_nettype none
package flash_guard_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int REG_AW = 4;
	// Main program area: 512-byte pages
	localparam int USER_PAGE_SHIFT = 9;
	localparam logic [15:0] USER_BASE = 16'h0000;
	localparam logic [15:0] USER_END = 16'h3fff;
	localparam logic [15:0] USER_LOCK_ADDR = 16'h3fff;
	// Data area: 1 KB in 64-byte pages
	localparam int DATA_PAGE_SHIFT = 6;
	localparam logic [15:0] DATA_BASE = 16'hf800;
	localparam logic [15:0] DATA_END = 16'hfbff;
	localparam logic [15:0] DATA_LOCK_ADDR = 16'hfbff;
	localparam logic [15:0] ROM_BASE = 16'hfc00;
	localparam logic [15:0] ROM_END = 16'hffff;
	localparam logic [7:0] LOCK_OPEN = 8'hff;
	localparam logic [7:0] KEY_CODE_FIRST = 8'ha5;
	localparam logic [7:0] KEY_CODE_SECOND = 8'hf1;
	// Register offsets and control bits
	localparam logic [3:0] REG_CONTROL = 4'h0;
	localparam logic [3:0] REG_KEY = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam int CTRL_WE_BIT = 0;
	localparam int CTRL_EE_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;

	typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_ERASE} flash_op_t;
	typedef struct packed {
		flash_op_t op;
		logic [ADDR_W-1:0] addr;
	} flash_req_t;
	typedef enum logic [2:0] {
		AREA_USER_OPEN, AREA_USER_LOCKED, AREA_USER_SEC,
		AREA_DATA_OPEN, AREA_DATA_LOCKED, AREA_DATA_SEC,
		AREA_READ_ONLY, AREA_RESERVED
	} flash_area_t;
	typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED, KEY_DEAD}
		key_state_t;
endpackage : flash_guard_pkg
`default_nettype wire

// ===== core/flash_region_decode.sv
/*
 * Classifies one flash byte address into an area, locked or open,
 * from the two security bytes. Purely combinational.
 * Assumes the lock bytes are presented stable by the flash reader.
 */
`default_nettype none
module flash_region_decode
	import flash_guard_pkg::*;
(
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [7:0] userLockByte,
	input wire logic [7:0] dataLockByte,
	output flash_area_t area
);
	logic [7:0] lockCount;
	logic [ADDR_W-USER_PAGE_SHIFT-1:0] userPage;
	logic userSecPage;
	logic dataSecPage;
	logic dataLocked;

	always_comb begin
		lockCount = ~userLockByte;
		userPage = addr[ADDR_W-1:USER_PAGE_SHIFT];
		userSecPage = userPage ==
			USER_LOCK_ADDR[ADDR_W-1:USER_PAGE_SHIFT];
		dataSecPage = addr[ADDR_W-1:DATA_PAGE_SHIFT] ==
			DATA_LOCK_ADDR[ADDR_W-1:DATA_PAGE_SHIFT];
		dataLocked = dataLockByte != LOCK_OPEN;
		if (addr >= USER_BASE && addr <= USER_END) begin
			if (userSecPage) begin
				// Security page follows the byte, not the count
				area = (userLockByte == LOCK_OPEN) ?
					AREA_USER_OPEN : AREA_USER_SEC;
			end else if ({1'b0, userPage} < lockCount) begin
				area = AREA_USER_LOCKED;
			end else begin
				area = AREA_USER_OPEN;
			end
		end else if (addr >= DATA_BASE && addr <= DATA_END) begin
			if (!dataLocked) begin
				area = AREA_DATA_OPEN;
			end else if (dataSecPage) begin
				area = AREA_DATA_SEC;
			end else begin
				area = AREA_DATA_LOCKED;
			end
		end else if (addr >= ROM_BASE && addr <= ROM_END) begin
			area = AREA_READ_ONLY;
		end else begin
			area = AREA_RESERVED;
		end
	end
endmodule : flash_region_decode
`default_nettype wire

// ===== verif/flash_access_guard_chk.sv
/* Port checker for the flash access guard.
 * Assumes it is bound to the guard's top module. */
`default_nettype none
module flash_access_guard_chk
	import flash_guard_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [REG_AW-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [DATA_W-1:0] regRdata,
	input wire logic reqValid,
	input wire flash_req_t req,
	input wire logic [ADDR_W-1:0] execAddr,
	input wire logic [7:0] userLockByte,
	input wire logic [7:0] dataLockByte,
	input wire logic supplyMonOn,
	input wire logic supplyMonIsReset,
	input wire logic grantValid,
	input wire flash_req_t grant,
	input wire logic refused,
	input wire logic flashErrorReset
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	logic [1:0] ctl_reg;
	logic [1:0] ctl_next;
	always_comb begin
		ctl_next = ctl_reg;
		if (regWrite && regAddr == REG_CONTROL) ctl_next = regWdata[1:0];
	end
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) ctl_reg <= CTRL_RESET;
		else ctl_reg <= ctl_next;
	end
	////////////////////////////////////////
	sequence s_answer;
		$onehot({grantValid, refused, flashErrorReset});
	endsequence
	sequence s_quiet;
		!(grantValid || refused || flashErrorReset);
	endsequence
	a_one_answer: assert property (reqValid |=> s_answer)
		else $error("request without exactly one answer");
	a_quiet_idle: assert property (!reqValid |=> s_quiet)
		else $error("answer without request");
	a_grant_copy: assert property (grantValid |-> grant == $past(req))
		else $error("grant differs from request");
	a_write_we: assert property (reqValid && req.op == OP_WRITE &&
		!ctl_reg[CTRL_WE_BIT] |=> !grantValid)
		else $error("write granted without write enable");
	a_erase_both: assert property (reqValid && req.op == OP_ERASE &&
		ctl_reg != 2'h3 |=> !grantValid)
		else $error("erase granted without both enables");
	a_supply_off: assert property (reqValid && req.op != OP_READ &&
		!(supplyMonOn && supplyMonIsReset) |=> !grantValid)
		else $error("write or erase granted with supply monitor off");
	a_rom_read: assert property (reqValid && req.addr >= ROM_BASE
		|=> grantValid == ($past(req.op) == OP_READ))
		else $error("read-only area judged wrongly");
	a_open_user: assert property (reqValid && req.op == OP_READ &&
		req.addr <= USER_END && userLockByte == LOCK_OPEN |=> grantValid)
		else $error("open user read not granted");
	a_data_lock: assert property (reqValid && req.addr >= DATA_BASE &&
		req.addr <= DATA_END && dataLockByte != LOCK_OPEN &&
		userLockByte == LOCK_OPEN && execAddr <= USER_END
		|=> flashErrorReset)
		else $error("locked data reached from open code");
	a_rdata_zero: assert property (!regRead |=> regRdata == 8'h00)
		else $error("read data outside read answer");
endmodule : flash_access_guard_chk
bind flash_access_guard flash_access_guard_chk u_chk (.sys_clk, .nrst,
	.regAddr, .regWdata, .regWrite, .regRead, .regRdata, .reqValid, .req,
	.execAddr, .userLockByte, .dataLockByte, .supplyMonOn,
	.supplyMonIsReset, .grantValid, .grant, .refused, .flashErrorReset);
`default_nettype wire

// ===== verif/flash_access_guard_tb.sv
/* Self-checking bench for the flash access guard.
 * Assumes the CPU model and the bound checker are compiled alongside. */
`default_nettype none
module flash_access_guard_tb import flash_guard_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [2:0] G = 3'b100, RF = 3'b010, ER = 3'b001;
	logic sys_clk = 1'b0, nrst = 1'b0, regWrite = 1'b0, regRead = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWdata = 8'h00, regRdata;
	logic [7:0] userLockByte = 8'hff, dataLockByte = 8'hff;
	logic supplyMonOn = 1'b1, supplyMonIsReset = 1'b1;
	logic reqValid, grantValid, refused, flashErrorReset;
	logic [15:0] execAddr;
	flash_req_t req, grant;
	int err_count = 0, check_count = 0;
	always #10 sys_clk = ~sys_clk;
	flash_access_guard u_dut (.sys_clk, .nrst, .regAddr, .regWdata,
		.regWrite, .regRead, .regRdata, .reqValid, .req, .execAddr,
		.userLockByte, .dataLockByte, .supplyMonOn, .supplyMonIsReset,
		.grantValid, .grant, .refused, .flashErrorReset);
	flash_cpu_model u_cpu (.sys_clk, .grantValid, .refused,
		.flashErrorReset, .reqValid, .req, .execAddr);
	////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge sys_clk);
		regWrite <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRead <= 1'b0;
		#1 chk(regRdata, exp);
	endtask : rd
	task automatic acc(input flash_op_t op, input logic [15:0] a, x,
		input logic [2:0] exp);
		logic [2:0] r;
		u_cpu.issue(op, a, x, r);
		chk({5'h00, r}, {5'h00, exp});
		if (exp == G) begin
			// Granted request passes on unchanged
			chk(grant.addr[7:0], a[7:0]);
			chk(grant.addr[15:8], a[15:8]);
			chk({6'h00, grant.op}, {6'h00, op});
		end
	endtask : acc
	task automatic reset_dut;
		@(posedge sys_clk);
		nrst <= 1'b0;
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
	endtask : reset_dut
	task automatic keys;
		wr(REG_KEY, KEY_CODE_FIRST);
		wr(REG_KEY, KEY_CODE_SECOND);
	endtask : keys
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	////////////////////////////////////////
	task automatic s_pages;
		userLockByte <= 8'hfd;
		dataLockByte <= 8'h00;
		rd(REG_STATUS, 8'h03);
		acc(OP_READ, 16'h03ff, 16'h1000, ER);
		acc(OP_READ, 16'h0400, 16'h1000, G);
		acc(OP_READ, 16'h03ff, 16'h0000, G);
		acc(OP_READ, 16'h3e00, 16'h1000, ER);
		acc(OP_ERASE, 16'h3e00, 16'h0000, RF);
		acc(OP_READ, 16'hf800, 16'h1000, ER);
		acc(OP_READ, 16'hfbff, 16'h0200, G);
		acc(OP_ERASE, 16'hfbc0, 16'h0000, RF);
		acc(OP_WRITE, 16'hfc00, 16'h0000, RF);
		acc(OP_READ, 16'hfc00, 16'h1000, G);
		@(posedge sys_clk);
		dataLockByte <= 8'hff;
		userLockByte <= 8'hff;
		acc(OP_READ, 16'hfbff, 16'h1000, G);
		acc(OP_READ, 16'hf800, 16'hf840, G);
	endtask : s_pages
	task automatic s_flow;
		rd(REG_CONTROL, 8'h00);
		acc(OP_WRITE, 16'h1000, 16'h2000, RF);
		rd(REG_KEY, 8'h00);
		wr(REG_CONTROL, 8'h01);
		keys();
		rd(REG_KEY, 8'h02);
		acc(OP_ERASE, 16'h1000, 16'h2000, RF);
		rd(REG_KEY, 8'h02);
		acc(OP_WRITE, 16'h1000, 16'h2000, G);
		rd(REG_KEY, 8'h00);
		keys();
		supplyMonIsReset <= 1'b0;
		acc(OP_WRITE, 16'h1001, 16'h2000, ER);
		@(posedge sys_clk);
		supplyMonIsReset <= 1'b1;
		reset_dut();
		wr(REG_CONTROL, 8'h03);
		rd(REG_CONTROL, 8'h03);
		rd(4'hf, 8'h00);
		acc(OP_ERASE, 16'h1200, 16'h2000, RF);
		rd(REG_KEY, 8'h03);
		reset_dut();
		wr(REG_KEY, KEY_CODE_SECOND);
		rd(REG_KEY, 8'h03);
	endtask : s_flow
	initial begin
		reset_dut();
		s_pages();
		s_flow();
		wrap_up();
	end
	initial begin
		#200000;
		err_count++;
		wrap_up();
	end
endmodule : flash_access_guard_tb
`default_nettype wire

// ===== verif/flash_cpu_model.sv
/* CPU-side model issuing flash accesses.
 * Assumes the guard answers one cycle after it takes a request. */
`default_nettype none
module flash_cpu_model
	import flash_guard_pkg::*;
(
	input wire logic sys_clk,
	input wire logic grantValid,
	input wire logic refused,
	input wire logic flashErrorReset,
	output logic reqValid,
	output flash_req_t req,
	output logic [15:0] execAddr
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		reqValid = 1'b0;
		req = '{OP_READ, 16'h0000};
		execAddr = 16'h0000;
	end
	// Callers never write one byte twice between erases
	task automatic issue(input flash_op_t op, input logic [15:0] a, x,
		output logic [2:0] res);
		@(posedge sys_clk);
		reqValid <= 1'b1;
		req <= '{op, a};
		execAddr <= x;
		@(posedge sys_clk);
		reqValid <= 1'b0;
		// Released address lines show the inverse, not a stale value
		req.addr <= ~a;
		execAddr <= ~x;
		#1 res = {grantValid, refused, flashErrorReset};
	endtask : issue
endmodule : flash_cpu_model
`default_nettype wire
